//--- ccr_config_regs.sv
// Purpose: Configuration register bank behind the serial control port
// Assumes: sclk at most clk_i/8; pins are asynchronous to clk_i
// Notes: One byte per frame: R/W bit, 15-bit address, 8 data bits, MSB first
//        A frame cut short by chip select commits nothing
//        Unmapped addresses ignore writes and read as zero
//        Field outputs move one clock after the write commits
`timescale 1ns/10ps
module ccr_config_regs #(
   parameter int FS8_TICK_CYCLES = ccr_pkg::FS8_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic spi_csb_n_i,
   input wire logic spi_sclk_i,
   input wire logic spi_sdio_i,
   output logic spi_sdio_o,
   output logic spi_sdio_oe_o,
   input wire logic cap_measure_start_i,
   output logic common_mode_force_select_o,
   output logic input_high_impedance_o,
   output logic [1:0] termination_select_o,
   output logic adc_digital_clock_enable_o,
   output logic [21:0] gain_constant_o,
   output logic [5:0] center_offset_o,
   output logic [7:0] temp_diode_trim_o,
   output logic [1:0] monitor_source_select_o,
   output logic vco_cal_start_o,
   output logic [1:0] reference_predivide_o,
   output logic [5:0] pump_current_setting_o,
   output logic [7:0] pll_divider_setting_o,
   output logic cap_reset_o,
   output logic cap_ramp_clk_o,
   output logic cap_measure_busy_o
);
   import ccr_pkg::*;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // Returns {hit, index}; shared by write commit and read fetch
   function automatic logic [CCR_IDX_W:0] ccr_decode(input logic [CCR_ADDR_W-1:0] a);
      logic [CCR_IDX_W:0] r;
      r = '0;
      for (int i = 0; i < CCR_NUM_REGS; i++) begin
         if (a == CCR_REG_ADDR[i]) begin
            r = {1'b1, CCR_IDX_W'(i)};
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Third sclk stage only feeds the edge detector, never the logic
   logic csb_s1, csb_s2, sclk_s1, sclk_s2, sclk_s3, sdio_s1, sdio_s2;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         csb_s1 <= 1'b1;
         csb_s2 <= 1'b1;
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         sdio_s1 <= 1'b0;
         sdio_s2 <= 1'b0;
      end else begin
         csb_s1 <= spi_csb_n_i;
         csb_s2 <= csb_s1;
         sclk_s1 <= spi_sclk_i;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         sdio_s1 <= spi_sdio_i;
         sdio_s2 <= sdio_s1;
      end
   end

   // ------------------------------------------------------------
   // Serial frame engine
   // ------------------------------------------------------------
   ccr_spi_state_e state, next_state;
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [CCR_ADDR_W-1:0] shift, next_shift;
   logic [CCR_ADDR_W-1:0] addr_q, next_addr_q;
   logic rd_q, next_rd_q;
   logic [7:0] out_shift, next_out_shift;
   logic next_sdio, next_sdio_oe;
   logic wr_en, next_wr_en;
   logic [CCR_IDX_W-1:0] wr_idx, next_wr_idx;
   logic [7:0] wr_data, next_wr_data;
   logic [7:0] regs [CCR_NUM_REGS];
   logic sclk_rise, sclk_fall;
   logic [CCR_IDX_W:0] rd_hit;
   logic [CCR_IDX_W:0] wr_hit;

   // Edge detect and decode feed both the frame engine and the commit
   always_comb begin
      sclk_rise = sclk_s2 & ~sclk_s3;
      sclk_fall = ~sclk_s2 & sclk_s3;
      // Read fetch looks at the address as it stands after this bit
      rd_hit = ccr_decode({shift[CCR_ADDR_W-2:0], sdio_s2});
      wr_hit = ccr_decode(addr_q);
   end

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_addr_q = addr_q;
      next_rd_q = rd_q;
      next_out_shift = out_shift;
      next_sdio = spi_sdio_o;
      next_sdio_oe = spi_sdio_oe_o;
      if (csb_s2) begin
         // Deselect aborts any frame and releases the data pin
         next_state = SPI_IDLE;
         next_sdio_oe = 1'b0;
      end else begin
         unique case (state)
            SPI_IDLE: begin
               next_state = SPI_CMD;
               next_bit_cnt = '0;
            end
            SPI_CMD: begin
               if (sclk_rise) begin
                  next_shift = {shift[CCR_ADDR_W-2:0], sdio_s2};
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (bit_cnt == CMD_LAST_BIT) begin
                     next_state = SPI_DATA;
                     next_rd_q = shift[CCR_ADDR_W-1];
                     next_addr_q = {shift[CCR_ADDR_W-2:0], sdio_s2};
                     if (shift[CCR_ADDR_W-1]) begin
                        // Unmapped addresses read as zero
                        next_out_shift = rd_hit[CCR_IDX_W] ?
                           regs[rd_hit[CCR_IDX_W-1:0]] : 8'h00;
                        next_sdio = next_out_shift[7];
                        next_out_shift = {next_out_shift[6:0], 1'b0};
                        next_sdio_oe = 1'b1;
                     end
                  end
               end
            end
            SPI_DATA: begin
               if (sclk_fall && rd_q) begin
                  next_sdio = out_shift[7];
                  next_out_shift = {out_shift[6:0], 1'b0};
               end
               if (sclk_rise) begin
                  next_shift = {shift[CCR_ADDR_W-2:0], sdio_s2};
                  next_bit_cnt = bit_cnt + 5'h01;
                  if (bit_cnt == FRAME_LAST_BIT) begin
                     next_state = SPI_DONE;
                     next_sdio_oe = 1'b0;
                  end
               end
            end
            SPI_DONE: next_state = SPI_DONE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= SPI_IDLE;
         bit_cnt <= '0;
         shift <= '0;
         addr_q <= '0;
         rd_q <= 1'b0;
         out_shift <= '0;
         spi_sdio_o <= 1'b0;
         spi_sdio_oe_o <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         addr_q <= next_addr_q;
         rd_q <= next_rd_q;
         out_shift <= next_out_shift;
         spi_sdio_o <= next_sdio;
         spi_sdio_oe_o <= next_sdio_oe;
      end
   end

   // ------------------------------------------------------------
   // Write commit
   // ------------------------------------------------------------
   // Commit only on the last data bit; a cut frame never gets here
   always_comb begin
      next_wr_en = 1'b0;
      next_wr_idx = wr_idx;
      next_wr_data = wr_data;
      if (!csb_s2 && state == SPI_DATA && sclk_rise && bit_cnt == FRAME_LAST_BIT) begin
         next_wr_en = ~rd_q & wr_hit[CCR_IDX_W];
         next_wr_idx = wr_hit[CCR_IDX_W-1:0];
         next_wr_data = {shift[6:0], sdio_s2};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_en <= 1'b0;
         wr_idx <= '0;
         wr_data <= '0;
      end else begin
         wr_en <= next_wr_en;
         wr_idx <= next_wr_idx;
         wr_data <= next_wr_data;
      end
   end

   // ------------------------------------------------------------
   // Register store
   // ------------------------------------------------------------
   logic [7:0] next_regs [CCR_NUM_REGS];

   always_comb begin
      for (int i = 0; i < CCR_NUM_REGS; i++) begin
         next_regs[i] = regs[i];
      end
      if (wr_en) begin
         // Read-only bits keep their reset value
         next_regs[wr_idx] = (wr_data & CCR_REG_WMASK[wr_idx]) |
            (CCR_REG_RESET[wr_idx] & ~CCR_REG_WMASK[wr_idx]);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < CCR_NUM_REGS; i++) begin
            regs[i] <= CCR_REG_RESET[i];
         end
      end else begin
         for (int i = 0; i < CCR_NUM_REGS; i++) begin
            regs[i] <= next_regs[i];
         end
      end
   end

   // ------------------------------------------------------------
   // Field outputs
   // ------------------------------------------------------------
   logic cal_bit_q, next_vco_cal_start;

   assign common_mode_force_select_o = regs[IDX_FRONTEND][FORCE_CM_BIT];
   assign input_high_impedance_o = regs[IDX_FRONTEND][HIGH_IMP_BIT];
   assign termination_select_o = regs[IDX_FRONTEND][TERM_MSB:TERM_LSB];
   assign adc_digital_clock_enable_o = regs[IDX_CAL_EN][DIG_CLK_EN_BIT];
   assign gain_constant_o = {regs[IDX_GAIN_HI][GAIN_HI_MSB:0],
      regs[IDX_GAIN_MID], regs[IDX_GAIN_LO]};
   assign center_offset_o = regs[IDX_CENTER][CENTER_MSB:CENTER_LSB];
   assign temp_diode_trim_o = regs[IDX_DIODE_TRIM];
   assign monitor_source_select_o = regs[IDX_MONITOR][MON_MSB:MON_LSB];
   assign reference_predivide_o = regs[IDX_PREDIV][PREDIV_MSB:0];
   assign pump_current_setting_o = regs[IDX_PUMP][PUMP_MSB:0];
   assign pll_divider_setting_o = regs[IDX_PLL_DIV];

   // ------------------------------------------------------------
   // Calibration start
   // ------------------------------------------------------------
   // Edge taken on the stored bit, so rewriting a 1 starts nothing
   always_comb begin
      next_vco_cal_start = regs[IDX_PLL_RESET][CAL_RESET_BIT] & ~cal_bit_q;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cal_bit_q <= 1'b0;
         vco_cal_start_o <= 1'b0;
      end else begin
         cal_bit_q <= regs[IDX_PLL_RESET][CAL_RESET_BIT];
         vco_cal_start_o <= next_vco_cal_start;
      end
   end

   // ------------------------------------------------------------
   // Capacitor measurement timing
   // ------------------------------------------------------------
   // Timer latches the count at start, so a later write cannot stretch a run
   ccr_cap_timer #(
      .WAIT_W(CCR_DATA_W),
      .TICK_CYCLES(FS8_TICK_CYCLES)
   ) u_cap_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .start_i(cap_measure_start_i),
      .wait_count_i(regs[IDX_CAP_WAIT]),
      .cap_reset_o(cap_reset_o),
      .cap_ramp_clk_o(cap_ramp_clk_o),
      .busy_o(cap_measure_busy_o)
   );
endmodule // ccr_config_regs

//--- ccr_pkg.sv
// Purpose: Constants for the converter configuration register bank
// Assumes: Byte registers reached over a three-pin serial control port
// Notes: Register table is index based; address, reset and write mask per entry
package ccr_pkg;
   localparam int CCR_ADDR_W = 15;
   localparam int CCR_DATA_W = 8;
   localparam int CCR_NUM_REGS = 13;
   localparam int CCR_IDX_W = 4;

   // ------------------------------------------------------------
   // Register indices
   // ------------------------------------------------------------
   localparam int IDX_FRONTEND = 0;
   localparam int IDX_CAL_EN = 1;
   localparam int IDX_GAIN_LO = 2;
   localparam int IDX_GAIN_MID = 3;
   localparam int IDX_GAIN_HI = 4;
   localparam int IDX_CENTER = 5;
   localparam int IDX_CAP_WAIT = 6;
   localparam int IDX_DIODE_TRIM = 7;
   localparam int IDX_MONITOR = 8;
   localparam int IDX_PLL_RESET = 9;
   localparam int IDX_PREDIV = 10;
   localparam int IDX_PUMP = 11;
   localparam int IDX_PLL_DIV = 12;

   // ------------------------------------------------------------
   // Map: address, reset value, writable bits
   // ------------------------------------------------------------
   localparam logic [14:0] CCR_REG_ADDR [CCR_NUM_REGS] = '{
      15'h0ba2, 15'h0bb3, 15'h0bba, 15'h0bbb, 15'h0bbc, 15'h0bc3, 15'h0bc8,
      15'h0c01, 15'h0c04, 15'h0d02, 15'h0d03, 15'h0d04, 15'h0d09};
   localparam logic [7:0] CCR_REG_RESET [CCR_NUM_REGS] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7d,
      8'h00, 8'h00, 8'h00, 8'h10, 8'h13, 8'h00};
   localparam logic [7:0] CCR_REG_WMASK [CCR_NUM_REGS] = '{
      8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hfc, 8'hff,
      8'hff, 8'h0f, 8'h03, 8'h03, 8'hff, 8'hff};

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int FORCE_CM_BIT = 7;
   localparam int HIGH_IMP_BIT = 6;
   localparam int TERM_MSB = 5;
   localparam int TERM_LSB = 4;
   localparam int DIG_CLK_EN_BIT = 7;
   localparam int GAIN_HI_MSB = 5;
   localparam int CENTER_MSB = 7;
   localparam int CENTER_LSB = 2;
   localparam int MON_MSB = 3;
   localparam int MON_LSB = 2;
   localparam int CAL_RESET_BIT = 1;
   localparam int PREDIV_MSB = 1;
   localparam int PUMP_MSB = 5;

   // ------------------------------------------------------------
   // Serial frame and timing
   // ------------------------------------------------------------
   localparam logic [4:0] CMD_LAST_BIT = 5'h0f;
   localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int FS8_PERIOD_PS = 4000;
   localparam int FS8_CYCLES_RAW = FS8_PERIOD_PS / CLK_PERIOD_PS;
   localparam int FS8_CYCLES = (FS8_CYCLES_RAW < 1) ? 1 : FS8_CYCLES_RAW;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_CMD = 2'b01,
      SPI_DATA = 2'b11,
      SPI_DONE = 2'b10
   } ccr_spi_state_e;

   typedef enum logic [1:0] {
      CAP_IDLE = 2'b00,
      CAP_RESET = 2'b01,
      CAP_WAIT = 2'b11
   } ccr_cap_state_e;
endpackage

//--- ccr_cap_timer.sv
// Purpose: Capacitor measurement reset and ramp clock sequencer
// Assumes: One fs/8 period is TICK_CYCLES clk_i cycles
// Notes: Ramp clock falls exactly wait_count ticks after reset falls, one tick for a zero count
`timescale 1ns/10ps
module ccr_cap_timer #(
   parameter int WAIT_W = 8,
   parameter int TICK_CYCLES = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [WAIT_W-1:0] wait_count_i,
   output logic cap_reset_o,
   output logic cap_ramp_clk_o,
   output logic busy_o
);
   import ccr_pkg::*;

   localparam int TICK_W = (TICK_CYCLES < 2) ? 1 : $clog2(TICK_CYCLES);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   ccr_cap_state_e state, next_state;
   logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
   logic [WAIT_W-1:0] period_cnt, next_period_cnt;
   logic [WAIT_W-1:0] wait_q, next_wait_q;
   logic next_cap_reset, next_cap_ramp_clk, next_busy;
   logic tick;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_wait_q = wait_q;
      next_period_cnt = period_cnt;
      tick = (tick_cnt == TICK_LAST);
      next_tick_cnt = tick ? '0 : tick_cnt + TICK_W'(1);
      unique case (state)
         CAP_IDLE: begin
            next_tick_cnt = '0;
            if (start_i) begin
               next_state = CAP_RESET;
               next_wait_q = wait_count_i;
            end
         end
         CAP_RESET: begin
            if (tick) begin
               next_state = CAP_WAIT;
               next_period_cnt = '0;
            end
         end
         CAP_WAIT: begin
            if (tick) begin
               next_period_cnt = period_cnt + WAIT_W'(1);
               // Zero count is outside the legal range; end at the first tick
               if (next_period_cnt >= wait_q) begin
                  next_state = CAP_IDLE;
               end
            end
         end
         default: next_state = CAP_IDLE;
      endcase
      next_cap_reset = (next_state == CAP_RESET);
      next_cap_ramp_clk = (next_state != CAP_IDLE);
      next_busy = (next_state != CAP_IDLE);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= CAP_IDLE;
         tick_cnt <= '0;
         period_cnt <= '0;
         wait_q <= '0;
         cap_reset_o <= 1'b0;
         cap_ramp_clk_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         state <= next_state;
         tick_cnt <= next_tick_cnt;
         period_cnt <= next_period_cnt;
         wait_q <= next_wait_q;
         cap_reset_o <= next_cap_reset;
         cap_ramp_clk_o <= next_cap_ramp_clk;
         busy_o <= next_busy;
      end
   end
endmodule // ccr_cap_timer

//--- ccr_config_regs_asserts.sv
// Purpose: Port-level checker for the configuration register bank
// Assumes: Bound to ccr_config_regs; one clock domain
// Notes: Field outputs except termination and PLL divider must hold once chip select has been high 8 clocks
`timescale 1ns/10ps
module ccr_config_regs_asserts #(
   parameter int FS8_TICK_CYCLES = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic spi_csb_n_i,
   input wire logic cap_measure_start_i,
   input wire logic common_mode_force_select_o,
   input wire logic input_high_impedance_o,
   input wire logic adc_digital_clock_enable_o,
   input wire logic [21:0] gain_constant_o,
   input wire logic [5:0] center_offset_o,
   input wire logic [7:0] temp_diode_trim_o,
   input wire logic [1:0] monitor_source_select_o,
   input wire logic vco_cal_start_o,
   input wire logic [1:0] reference_predivide_o,
   input wire logic [5:0] pump_current_setting_o,
   input wire logic cap_reset_o,
   input wire logic cap_ramp_clk_o,
   input wire logic cap_measure_busy_o
);
   logic [15:0] hi_cnt;
   logic [15:0] next_hi_cnt;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // Length of the measurement reset pulse in clocks
   always_comb begin
      next_hi_cnt = cap_reset_o ? hi_cnt + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hi_cnt <= 16'h0000;
      end else begin
         hi_cnt <= next_hi_cnt;
      end
   end

   reset_value_a: assert property ($rose(rst_n_i)
      |-> pump_current_setting_o == 6'h13
      && !adc_digital_clock_enable_o && gain_constant_o == 22'h000000)
      else $error("field not at reset value");
   vco_pulse_a: assert property (vco_cal_start_o |=> !vco_cal_start_o)
      else $error("calibration start longer than one cycle");
   vco_quiet_a: assert property (spi_csb_n_i [*8] |-> !vco_cal_start_o)
      else $error("calibration start without a write");
   cap_start_a: assert property (cap_measure_start_i && !cap_measure_busy_o
      |=> cap_reset_o && cap_ramp_clk_o && cap_measure_busy_o)
      else $error("measurement did not start");
   cap_reset_len_a: assert property ($fell(cap_reset_o)
      |-> hi_cnt == FS8_TICK_CYCLES)
      else $error("measurement reset length wrong");
   cap_nest_a: assert property (cap_reset_o || $fell(cap_reset_o)
      |-> cap_ramp_clk_o)
      else $error("ramp clock low while reset active");
   frontend_quiet_a: assert property (spi_csb_n_i [*8]
      |-> $stable({common_mode_force_select_o, input_high_impedance_o,
      adc_digital_clock_enable_o}))
      else $error("front-end field moved without a write");
   gain_quiet_a: assert property (spi_csb_n_i [*8]
      |-> $stable({gain_constant_o, center_offset_o}))
      else $error("gain or offset moved without a write");
   pll_quiet_a: assert property (spi_csb_n_i [*8]
      |-> $stable({temp_diode_trim_o, monitor_source_select_o, reference_predivide_o,
      pump_current_setting_o}))
      else $error("monitor or pll field moved without a write");
endmodule // ccr_config_regs_asserts

bind ccr_config_regs ccr_config_regs_asserts #(.FS8_TICK_CYCLES(FS8_TICK_CYCLES)) u_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .spi_csb_n_i(spi_csb_n_i),
   .cap_measure_start_i(cap_measure_start_i),
   .common_mode_force_select_o(common_mode_force_select_o),
   .input_high_impedance_o(input_high_impedance_o),
   .adc_digital_clock_enable_o(adc_digital_clock_enable_o),
   .gain_constant_o(gain_constant_o), .center_offset_o(center_offset_o),
   .temp_diode_trim_o(temp_diode_trim_o), .monitor_source_select_o(monitor_source_select_o),
   .vco_cal_start_o(vco_cal_start_o), .reference_predivide_o(reference_predivide_o),
   .pump_current_setting_o(pump_current_setting_o), .cap_reset_o(cap_reset_o),
   .cap_ramp_clk_o(cap_ramp_clk_o), .cap_measure_busy_o(cap_measure_busy_o));

//--- test_converter_config_regs.sv
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Serial frames of 24 bits, sclk half period of 8 clocks
// Notes: Inputs move on the falling clock edge only
`timescale 1ns/10ps
module test_converter_config_regs;
   import ccr_pkg::*;
   localparam int TICK = 2;
   localparam logic [7:0] RV [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7d,
      8'h00, 8'h00, 8'h00, 8'h10, 8'h13, 8'h00};
   localparam logic [7:0] MK [13] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hfc, 8'hff,
      8'hff, 8'h0f, 8'h03, 8'h03, 8'hff, 8'hff};
   localparam logic [7:0] VC [5] = '{8'h02, 8'h02, 8'h03, 8'h00, 8'h02};
   localparam logic [7:0] VP [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
   logic clk_i = 1'b0;
   logic rst_n, csb, sclk, tb_sdio, sdio_line, start;
   logic spi_sdio_o, spi_sdio_oe_o, cmf, hiz, clk_en, vco, cap_reset_o, cap_ramp_clk_o, busy;
   logic [1:0] term, mon, prediv;
   logic [21:0] gain;
   logic [5:0] center, pump;
   logic [7:0] trim, pdiv, q, w, n0;
   logic [7:0] v [13];
   int errors, n_tests, cal_pulses;

   always #2.5 clk_i = ~clk_i;
   // Released line toggles so a stale value cannot pass for read data
   assign sdio_line = spi_sdio_oe_o ? spi_sdio_o : tb_sdio;
   always @(negedge clk_i) if (vco === 1'b1) cal_pulses++;

   ccr_config_regs #(.FS8_TICK_CYCLES(TICK)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n),
      .spi_csb_n_i(csb), .spi_sclk_i(sclk), .spi_sdio_i(sdio_line), .spi_sdio_o(spi_sdio_o),
      .spi_sdio_oe_o(spi_sdio_oe_o), .cap_measure_start_i(start),
      .common_mode_force_select_o(cmf), .input_high_impedance_o(hiz),
      .termination_select_o(term), .adc_digital_clock_enable_o(clk_en),
      .gain_constant_o(gain), .center_offset_o(center), .temp_diode_trim_o(trim),
      .monitor_source_select_o(mon), .vco_cal_start_o(vco), .reference_predivide_o(prediv),
      .pump_current_setting_o(pump), .pll_divider_setting_o(pdiv), .cap_reset_o(cap_reset_o),
      .cap_ramp_clk_o(cap_ramp_clk_o), .cap_measure_busy_o(busy));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] d);
      logic [23:0] f;
      f = {rw, a, d};
      q = 8'h00;
      csb = 1'b0;
      for (int i = 0; i < 24; i++) begin
         sclk = 1'b0;
         tb_sdio = (rw && i > 15) ? ~tb_sdio : f[23-i];
         repeat (8) @(negedge clk_i);
         sclk = 1'b1;
         repeat (8) @(negedge clk_i);
         if (rw && i > 14 && i < 23) q[22-i] = spi_sdio_oe_o ? spi_sdio_o : 1'bx;
      end
      sclk = 1'b0;
      repeat (8) @(negedge clk_i);
      csb = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask

   task automatic check_fields();
      check(cmf, v[0][7]);
      check(hiz, v[0][6]);
      check(term, v[0][5:4]);
      check(clk_en, v[1][7]);
      check(gain, {v[4][5:0], v[3], v[2]});
      check(center, v[5][7:2]);
      check(trim, v[7]);
      check(mon, v[8][3:2]);
      check(prediv, v[10][1:0]);
      check(pump, v[11][5:0]);
      check(pdiv, v[12]);
   endtask

   task automatic cap_run(input logic [7:0] wc);
      int hi, lo;
      hi = 0;
      lo = 0;
      xfer(1'b0, CCR_REG_ADDR[IDX_CAP_WAIT], wc);
      start = 1'b1;
      @(negedge clk_i);
      start = 1'b0;
      while (cap_reset_o === 1'b1 && hi < 100) begin
         hi++;
         @(negedge clk_i);
      end
      // Second start mid-ramp must not stretch the measurement
      while (cap_ramp_clk_o === 1'b1 && lo < 3000) begin
         start = (lo == 10);
         lo++;
         @(negedge clk_i);
      end
      start = 1'b0;
      check(hi, TICK);
      check(lo, wc * TICK);
      check(busy, 1'b0);
      if (hi >= 100 || lo >= 3000) stop_test();
      $display("test cap wait %h done", wc);
   endtask

   initial begin
      {csb, sclk, tb_sdio, start, rst_n} = 5'h10;
      errors = 0;
      n_tests = 0;
      cal_pulses = 0;
      repeat (16) @(negedge clk_i);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_i);
      v = RV;
      check_fields();
      for (int i = 0; i < 13; i++) begin
         xfer(1'b1, CCR_REG_ADDR[i], 8'h00);
         check(q, RV[i]);
      end
      $display("test reset values done");
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 13; i++) begin
            w = 8'h35 + 8'(i) * 8'h29;
            if (k == 1) w = ~w;
            if (i == IDX_CAP_WAIT) w = w | 8'h80;
            v[i] = (w & MK[i]) | (RV[i] & ~MK[i]);
            xfer(1'b0, CCR_REG_ADDR[i], w);
            xfer(1'b1, CCR_REG_ADDR[i], 8'h00);
            check(q, v[i]);
         end
         check_fields();
      end
      $display("test write patterns done");
      for (int c = 0; c < 4; c++) begin
         v[IDX_DIODE_TRIM] = (c == 1 || c == 2) ? 8'h03 : 8'h00;
         v[IDX_MONITOR] = 8'(c << 2);
         v[IDX_PREDIV] = 8'h10 | 8'(c);
         xfer(1'b0, CCR_REG_ADDR[IDX_DIODE_TRIM], v[IDX_DIODE_TRIM]);
         xfer(1'b0, CCR_REG_ADDR[IDX_MONITOR], v[IDX_MONITOR]);
         xfer(1'b0, CCR_REG_ADDR[IDX_PREDIV], v[IDX_PREDIV]);
         check_fields();
      end
      $display("test codes done");
      xfer(1'b0, CCR_REG_ADDR[IDX_PLL_RESET], 8'h00);
      for (int j = 0; j < 5; j++) begin
         n0 = 8'(cal_pulses);
         xfer(1'b0, CCR_REG_ADDR[IDX_PLL_RESET], VC[j]);
         repeat (4) @(negedge clk_i);
         check(8'(cal_pulses) - n0, VP[j]);
      end
      $display("test calibration start done");
      xfer(1'b0, 15'h0ba3, 8'ha5);
      xfer(1'b1, 15'h0ba3, 8'h00);
      check(q, 8'h00);
      // Unmapped write must leave every field alone
      check_fields();
      $display("test unmapped done");
      cap_run(8'h7d);
      cap_run(8'hff);
      stop_test();
   end
endmodule // test_converter_config_regs
